// >>> fwr_map.svh
/*
  timing constants and field positions for the flash write/reset host controller.
  assumes a 10 MHz system clock; counts are derived from printed times.
*/
`ifndef FWR_MAP_SVH
`define FWR_MAP_SVH
`define FWR_CLK_NS 100
`define FWR_WP_NS 45
`define FWR_WPH_NS 15
`define FWR_CYC_NS 60
`define FWR_RST_REC_NS 150
`define FWR_WREC_NS 30
`define FWR_ACC_SU_NS 200
`define FWR_RST_LOW_NS 100
`define FWR_RESUME_US 500
`define FWR_CHIP_ERASE_S 350
`define FWR_CEIL(t) (((t) + `FWR_CLK_NS - 1) / `FWR_CLK_NS)
`define FWR_WP_CYC `FWR_CEIL(`FWR_WP_NS)
`define FWR_WPH_CYC `FWR_CEIL(`FWR_WPH_NS)
`define FWR_CYC_CYC `FWR_CEIL(`FWR_CYC_NS)
`define FWR_RST_REC_CYC `FWR_CEIL(`FWR_RST_REC_NS)
`define FWR_WREC_CYC `FWR_CEIL(`FWR_WREC_NS)
`define FWR_ACC_SU_CYC `FWR_CEIL(`FWR_ACC_SU_NS)
`define FWR_RST_LOW_CYC `FWR_CEIL(`FWR_RST_LOW_NS)
`define FWR_RESUME_CYC `FWR_CEIL(`FWR_RESUME_US * 1000)
`define FWR_DONE_BIT 7
`endif

// >>> fwr_pkg.sv
/*
  types for the flash write/reset host controller.
  assumes fwr_map.svh is on the include path.
*/
package fwr_pkg;
  typedef enum logic [2:0]
  {
    FWR_OP_WRITE,
    FWR_OP_READ,
    FWR_OP_RESET,
    FWR_OP_SUSPEND,
    FWR_OP_RESUME
  } fwr_op_t;
  typedef enum logic [1:0]
  {
    FWR_POLL_NONE,
    FWR_POLL_OK,
    FWR_POLL_TIMEOUT
  } fwr_poll_t;
endpackage : fwr_pkg

// >>> fwr_tmr_if.sv
/*
  carries load/expire of one down counter between the controller and its timers.
  assumes one clock domain.
*/
`timescale 1ns/10ps
interface fwr_tmr_if #(parameter int W = 32);
  logic load;
  logic [W-1:0] value;
  logic expired;
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface : fwr_tmr_if

// >>> fwr_timer.sv
/*
  down counter: loads a cycle count, reports expiry when it reaches zero.
  assumes synchronous load pulse from the controller.
*/
`timescale 1ns/10ps
module fwr_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  fwr_tmr_if.tmr t
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= '0;
    else if (t.load)
      cnt_r <= t.value;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign t.expired = (cnt_r == '0);
endmodule : fwr_timer

// >>> fwr_host.sv
/*
  host controller driving an asynchronous parallel flash through its pins:
  write strobes, status reads, reset pin, accelerate pin and ready/busy polling.
  assumes flash pins are sampled synchronously to clk; dq is split into in/out/enable.
*/
`timescale 1ns/10ps
`include "fwr_map.svh"
module fwr_host #(
  parameter int DW = 16,
  parameter int AW = 21,
  parameter int TW = 32,
  parameter logic [TW-1:0] RESUME_CYC = TW'(`FWR_RESUME_CYC),
  parameter logic [TW-1:0] TIMEOUT_CYC = TW'(`FWR_CHIP_ERASE_S) * TW'(10000000)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // user command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fwr_pkg::fwr_op_t cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_data,
  input wire logic cmd_starts_op,
  input wire logic cmd_accel,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output fwr_pkg::fwr_poll_t rsp_poll,
  output logic busy,
  // flash pins
  output logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] fl_dq_in,
  output logic [DW-1:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic fl_ce_b,
  output logic fl_we_b,
  output logic fl_oe_b,
  output logic fl_rst_b,
  output logic protect_accel_pin,
  input wire logic ready_busy_out
);
  typedef enum logic [3:0]
  {
    ST_PWRUP,
    ST_RECOVER,
    ST_IDLE,
    ST_WSETUP,
    ST_WLOW,
    ST_WHIGH,
    ST_RLOW,
    ST_RHIGH,
    ST_POLL,
    ST_RST
  } fwr_st_t;

  fwr_st_t st_r;
  fwr_pkg::fwr_op_t op_r;
  logic pend_r;
  logic cmd_starts_op_r;
  logic accel_r;

  fwr_tmr_if #(.W(TW)) ph ();
  fwr_tmr_if #(.W(TW)) to ();
  fwr_tmr_if #(.W(TW)) rs ();

  fwr_timer #(.W(TW)) u_phase (.clk(clk), .rst_b(rst_b), .t(ph));
  fwr_timer #(.W(TW)) u_tout (.clk(clk), .rst_b(rst_b), .t(to));
  fwr_timer #(.W(TW)) u_resume (.clk(clk), .rst_b(rst_b), .t(rs));

  // ----------------------------------------
  // handshake
  // ----------------------------------------
  assign cmd_ready = (st_r == ST_IDLE) && !pend_r && ph.expired &&
    !(cmd_op == fwr_pkg::FWR_OP_SUSPEND && !rs.expired);
  assign busy = pend_r;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= ST_PWRUP;
    else
    begin
      case (st_r)
        ST_PWRUP, ST_RST:
          if (ph.expired)
            st_r <= ST_RECOVER;
        ST_RECOVER:
          if (ph.expired)
            st_r <= ST_IDLE;
        ST_IDLE:
          if (pend_r && ph.expired)
            st_r <= ST_POLL;
          else if (cmd_valid && cmd_ready)
          begin
            case (cmd_op)
              fwr_pkg::FWR_OP_READ: st_r <= ST_RLOW;
              fwr_pkg::FWR_OP_RESET: st_r <= ST_RST;
              default: st_r <= ST_WSETUP;
            endcase
          end
        ST_WSETUP:
          if (ph.expired)
            st_r <= ST_WLOW;
        ST_WLOW:
          if (ph.expired)
            st_r <= ST_WHIGH;
        ST_WHIGH:
          if (ph.expired)
            st_r <= ST_IDLE;
        ST_RLOW:
          if (ph.expired)
            st_r <= ST_RHIGH;
        ST_RHIGH:
          if (ph.expired)
            st_r <= ST_IDLE;
        ST_POLL:
          if (ready_busy_out || to.expired)
            st_r <= ST_RECOVER;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // phase timer loads
  // ----------------------------------------
  always_comb
  begin
    ph.load = 1'b0;
    ph.value = '0;
    case (st_r)
      ST_IDLE:
        if (!pend_r && cmd_valid && cmd_ready)
        begin
          ph.load = 1'b1;
          if (cmd_op == fwr_pkg::FWR_OP_READ)
            ph.value = TW'(`FWR_CYC_CYC);
          else if (cmd_op == fwr_pkg::FWR_OP_RESET)
            ph.value = TW'(`FWR_RST_LOW_CYC);
          else
            ph.value = cmd_accel ? TW'(`FWR_ACC_SU_CYC) : TW'(1);
        end
      ST_PWRUP, ST_RST:
        if (ph.expired)
        begin
          ph.load = 1'b1;
          ph.value = TW'(`FWR_RST_REC_CYC);
        end
      ST_POLL:
        if (ready_busy_out || to.expired)
        begin
          ph.load = 1'b1;
          ph.value = TW'(`FWR_RST_REC_CYC);
        end
      ST_WSETUP:
        if (ph.expired)
        begin
          ph.load = 1'b1;
          ph.value = TW'(`FWR_WP_CYC);
        end
      ST_WLOW:
        if (ph.expired)
        begin
          ph.load = 1'b1;
          ph.value = TW'(`FWR_WPH_CYC) > TW'(`FWR_WREC_CYC) ?
            TW'(`FWR_WPH_CYC) : TW'(`FWR_WREC_CYC);
        end
      ST_RLOW:
        if (ph.expired)
        begin
          ph.load = 1'b1;
          ph.value = TW'(`FWR_WPH_CYC);
        end
      default:
      begin
        ph.load = 1'b0;
        ph.value = '0;
      end
    endcase
  end

  // ----------------------------------------
  // operation tracking and timeout
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      op_r <= fwr_pkg::FWR_OP_WRITE;
    else if (st_r == ST_IDLE && cmd_valid && cmd_ready)
      op_r <= cmd_op;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pend_r <= 1'b0;
    else if (st_r == ST_RST)
      pend_r <= 1'b0;
    else if (st_r == ST_WHIGH && ph.expired && cmd_starts_op_r)
      pend_r <= 1'b1;
    else if (st_r == ST_POLL && (ready_busy_out || to.expired))
      pend_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cmd_starts_op_r <= 1'b0;
    else if (st_r == ST_IDLE && cmd_valid && cmd_ready)
      cmd_starts_op_r <= cmd_starts_op || cmd_op == fwr_pkg::FWR_OP_SUSPEND ||
        cmd_op == fwr_pkg::FWR_OP_RESUME;
  end

  assign to.load = (st_r == ST_WHIGH) && ph.expired && cmd_starts_op_r;
  assign to.value = TIMEOUT_CYC;

  assign rs.load = (st_r == ST_WHIGH) && ph.expired && (op_r == fwr_pkg::FWR_OP_RESUME);
  assign rs.value = RESUME_CYC;

  // ----------------------------------------
  // accelerate pin
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      accel_r <= 1'b0;
    else if (st_r == ST_IDLE && cmd_valid && cmd_ready && cmd_op != fwr_pkg::FWR_OP_READ)
      accel_r <= cmd_accel;
    else if (st_r == ST_POLL && (ready_busy_out || to.expired))
      accel_r <= 1'b0;
  end
  assign protect_accel_pin = accel_r;

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fl_addr <= '0;
      fl_dq_out <= '0;
    end
    else if (st_r == ST_IDLE && cmd_valid && cmd_ready)
    begin
      fl_addr <= cmd_addr;
      fl_dq_out <= cmd_data;
    end
  end

  assign fl_rst_b = !(st_r == ST_PWRUP || st_r == ST_RST);
  assign fl_ce_b = !(st_r == ST_WSETUP || st_r == ST_WLOW || st_r == ST_RLOW);
  assign fl_we_b = (st_r != ST_WLOW);
  assign fl_oe_b = (st_r != ST_RLOW);
  assign fl_dq_oe = (st_r == ST_WSETUP || st_r == ST_WLOW);

  // ----------------------------------------
  // response
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_poll <= fwr_pkg::FWR_POLL_NONE;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (st_r == ST_RLOW && ph.expired)
      begin
        rsp_valid <= 1'b1;
        rsp_data <= fl_dq_in;
        rsp_poll <= fwr_pkg::FWR_POLL_NONE;
      end
      else if (st_r == ST_POLL && (ready_busy_out || to.expired))
      begin
        rsp_valid <= 1'b1;
        rsp_poll <= ready_busy_out ? fwr_pkg::FWR_POLL_OK : fwr_pkg::FWR_POLL_TIMEOUT;
      end
    end
  end
endmodule : fwr_host

// >>> fwr_host_chk.sv
/*
  pin sequencing checker for fwr_host.
  assumes bind onto fwr_host, one clock domain.
*/
`timescale 1ns/10ps
module fwr_host_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fwr_pkg::fwr_op_t cmd_op,
  input wire logic cmd_accel,
  input wire logic rsp_valid,
  input wire logic busy,
  // flash pins
  input wire logic fl_dq_oe,
  input wire logic fl_ce_b,
  input wire logic fl_we_b,
  input wire logic fl_oe_b,
  input wire logic fl_rst_b,
  input wire logic protect_accel_pin,
  input wire logic ready_busy_out
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic take;
  assign take = cmd_valid && cmd_ready;
  sequence take_wr;
    take && cmd_op == fwr_pkg::FWR_OP_WRITE && !cmd_accel;
  endsequence
  sequence wr_pulse;
    (!fl_ce_b && fl_dq_oe && fl_we_b) [*2] ##1 (!fl_we_b) [*2] ##1 fl_we_b && fl_ce_b;
  endsequence
  sequence rd_pulse;
    (!fl_ce_b && !fl_oe_b) [*2] ##1 rsp_valid && fl_oe_b;
  endsequence
  write_walk_a: assert property (take_wr |=> wr_pulse)
    else $error("write strobe walk wrong");
  we_framed_a: assert property (!fl_we_b |-> !fl_ce_b && fl_dq_oe && fl_oe_b)
    else $error("write strobe outside select");
  strobe_high_a: assert property ($rose(fl_we_b) |=> fl_we_b)
    else $error("strobe high too short");
  cycle_space_a: assert property ($fell(fl_ce_b) |=> (!$fell(fl_ce_b)) [*2])
    else $error("cycles too close");
  rst_recover_a: assert property ($rose(fl_rst_b) |-> fl_we_b [*2])
    else $error("write too soon after reset");
  read_gap_a: assert property ($rose(fl_we_b) |-> fl_oe_b [*3])
    else $error("read too soon after write");
  accel_lead_a: assert property ($rose(fl_we_b) && protect_accel_pin |-> $past(protect_accel_pin, 2))
    else $error("accel lead too short");
  accel_hold_a: assert property ($fell(protect_accel_pin) |-> ready_busy_out)
    else $error("accel dropped while busy");
  rst_pulse_a: assert property (take && cmd_op == fwr_pkg::FWR_OP_RESET |-> ##[1:2] !fl_rst_b)
    else $error("reset op gave no pulse");
  busy_block_a: assert property (busy |-> !cmd_ready && fl_we_b && fl_ce_b)
    else $error("ready while busy");
  read_walk_a: assert property (take && cmd_op == fwr_pkg::FWR_OP_READ |=> rd_pulse)
    else $error("read walk wrong");
  resume_gap_a: assert property (take && cmd_op == fwr_pkg::FWR_OP_RESUME |=> (!(take && cmd_op == fwr_pkg::FWR_OP_SUSPEND)) [*8])
    else $error("suspend too soon");
endmodule : fwr_host_chk
bind fwr_host fwr_host_chk u_fwr_host_chk (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_accel(cmd_accel), .rsp_valid(rsp_valid),
  .busy(busy), .fl_dq_oe(fl_dq_oe), .fl_ce_b(fl_ce_b), .fl_we_b(fl_we_b), .fl_oe_b(fl_oe_b),
  .fl_rst_b(fl_rst_b), .protect_accel_pin(protect_accel_pin), .ready_busy_out(ready_busy_out));

// >>> fwr_flash_model.sv
/*
  behavioural flash device: write capture, status word, busy output, reset abort.
  assumes clk paces write capture and the busy timer; busy output already resolved with pull-up.
*/
`timescale 1ns/10ps
module fwr_flash_model #(
  parameter logic [15:0] GO_CODE = 16'h00a5 // arbitrary start code
) (
  // timer clock
  input wire logic clk,
  // flash pins
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_b,
  input wire logic fl_we_b,
  input wire logic fl_oe_b,
  input wire logic fl_rst_b,
  output logic [15:0] fl_dq_in,
  output logic ready_busy_out,
  // length of next started op
  input wire logic [15:0] busy_len
);
  logic pend_r;
  logic [15:0] cnt_r;
  logic [15:0] wdat_r;
  logic [15:0] last_r = 16'h0000;
  always_ff @(posedge clk)
  begin
    if (!fl_rst_b)
    begin
      pend_r <= 1'b0;
      cnt_r <= 16'h0000;
      wdat_r <= 16'h0000;
    end
    else if (!fl_we_b && !fl_ce_b && fl_dq_oe)
    begin
      pend_r <= 1'b1;
      wdat_r <= fl_dq_out;
    end
    else if (pend_r)
    begin
      pend_r <= 1'b0;
      cnt_r <= (wdat_r == GO_CODE) ? busy_len : 16'h0000;
    end
    else if (cnt_r != 16'h0000)
      cnt_r <= cnt_r - 16'h0001;
  end
  assign ready_busy_out = (cnt_r == 16'h0000);
  assign fl_dq_in = (!fl_ce_b && !fl_oe_b) ? {wdat_r[15:8], ready_busy_out, wdat_r[6:0]} : ~last_r;
  always_ff @(posedge clk)
    last_r <= fl_dq_in;
endmodule : fwr_flash_model

// >>> tb_top.sv
/*
  testbench for fwr_host against the flash model.
  assumes fwr_map.svh on the include path.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  fwr_pkg::fwr_op_t cmd_op = fwr_pkg::FWR_OP_READ;
  logic [15:0] cmd_data = 16'h0000;
  logic go = 1'b0;
  logic acc = 1'b0;
  logic [15:0] busy_len = 16'h0000;
  logic cmd_ready, rsp_valid, busy, dq_oe, ce_b, we_b, oe_b, frst_b, accel, rb;
  logic [15:0] rsp_data, dq_out, dq_in;
  logic [20:0] addr;
  fwr_pkg::fwr_poll_t rsp_poll;
  int error_cnt = 0;
  int cmp_count = 0;
  int n, cyc, t0;
  always #50 clk = ~clk;
  always @(posedge clk) cyc++;
  fwr_host #(.RESUME_CYC(32'h0000_0014), .TIMEOUT_CYC(32'h0000_0064)) u_fwr_host (.clk(clk),
    .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(21'h000010), .cmd_data(cmd_data), .cmd_starts_op(go), .cmd_accel(acc),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_poll(rsp_poll), .busy(busy),
    .fl_addr(addr), .fl_dq_in(dq_in), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe), .fl_ce_b(ce_b),
    .fl_we_b(we_b), .fl_oe_b(oe_b), .fl_rst_b(frst_b), .protect_accel_pin(accel),
    .ready_busy_out(rb));
  fwr_flash_model u_fwr_flash_model (.clk(clk), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe),
    .fl_ce_b(ce_b), .fl_we_b(we_b), .fl_oe_b(oe_b), .fl_rst_b(frst_b), .fl_dq_in(dq_in),
    .ready_busy_out(rb), .busy_len(busy_len));
  // -----
  // tasks
  // -----
  task results;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task tmo(input int k);
    if (k > 300)
    begin
      error_cnt++;
      $display("wrong value at %0t: wait bound", $time);
      results();
    end
  endtask : tmo
  task issue(input fwr_pkg::fwr_op_t op, input logic [15:0] d, input logic g, input logic a);
    @(negedge clk);
    cmd_op = op;
    cmd_data = d;
    go = g;
    acc = a;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1)
    begin
      @(negedge clk);
      n++;
      tmo(n);
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : issue
  task wait_rsp;
    n = 0;
    while (rsp_valid !== 1'b1)
    begin
      @(negedge clk);
      n++;
      tmo(n);
    end
  endtask : wait_rsp
  task t_reset;
    repeat (20) @(negedge clk);
    chk(frst_b, 1'b0, "reset pin");
    chk(we_b & ce_b & oe_b, 1'b1, "strobes idle");
    chk(cmd_ready, 1'b0, "ready in reset");
    rst_b = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1)
    begin
      @(negedge clk);
      n++;
      tmo(n);
    end
    chk(n >= 2, 1'b1, "recovery");
    $display("t_reset ended");
  endtask : t_reset
  task t_rw;
    issue(fwr_pkg::FWR_OP_WRITE, 16'h1234, 1'b0, 1'b0);
    issue(fwr_pkg::FWR_OP_READ, 16'h0000, 1'b0, 1'b0);
    wait_rsp();
    chk(rsp_data, 16'h12b4, "read back");
    chk(addr[15:0], 16'h0010, "address latched");
    chk({14'h0000, rsp_poll}, {14'h0000, fwr_pkg::FWR_POLL_NONE}, "poll kind");
    $display("t_rw ended");
  endtask : t_rw
  task t_op(input logic [15:0] len, input logic a, input fwr_pkg::fwr_poll_t want);
    busy_len = len;
    issue(fwr_pkg::FWR_OP_WRITE, 16'h00a5, 1'b1, a);
    repeat (7) @(negedge clk);
    chk(busy, 1'b1, "busy after start");
    chk(accel, a, "accel held");
    wait_rsp();
    chk({14'h0000, rsp_poll}, {14'h0000, want}, "poll result");
    chk(accel, 1'b0, "accel released");
    chk(n + 1 >= (want == fwr_pkg::FWR_POLL_OK ? int'(len) : 100), 1'b1, "busy length");
    $display("t_op ended");
  endtask : t_op
  task t_abort;
    issue(fwr_pkg::FWR_OP_RESET, 16'h0000, 1'b0, 1'b0);
    issue(fwr_pkg::FWR_OP_READ, 16'h0000, 1'b0, 1'b0);
    wait_rsp();
    chk(rsp_data[7], 1'b1, "done after abort");
    $display("t_abort ended");
  endtask : t_abort
  task t_susp;
    busy_len = 16'h0000;
    issue(fwr_pkg::FWR_OP_RESUME, 16'h0000, 1'b1, 1'b0);
    t0 = cyc;
    wait_rsp();
    issue(fwr_pkg::FWR_OP_SUSPEND, 16'h0000, 1'b1, 1'b0);
    chk(cyc - t0 >= 20, 1'b1, "resume gap");
    wait_rsp();
    chk({14'h0000, rsp_poll}, {14'h0000, fwr_pkg::FWR_POLL_OK}, "suspend poll");
    $display("t_susp ended");
  endtask : t_susp
  initial
  begin
    t_reset();
    t_rw();
    t_op(16'h0008, 1'b0, fwr_pkg::FWR_POLL_OK);
    t_op(16'h0004, 1'b1, fwr_pkg::FWR_POLL_OK);
    t_op(16'h0200, 1'b0, fwr_pkg::FWR_POLL_TIMEOUT);
    t_abort();
    t_susp();
    results();
  end
endmodule : tb_top
